// ==== sdp_pkg.sv ====
package sdp_pkg;

  // ****************************************************************
  // Link word layout
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int ADR_MSB = 12;
  localparam int ADR_LSB = 8;
  localparam int DAT_MSB = 7;

  // ****************************************************************
  // Opcodes and addresses
  // ****************************************************************
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_ACC_RD = 3'h1;
  localparam logic [2:0] OP_ACC_WT = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_WRITE = 3'h6;
  localparam logic [2:0] ECHO_CODE = 3'h7;
  localparam logic [4:0] ADDR_WIPER = 5'h00;
  localparam logic [4:0] ADDR_ACCESS = 5'h10;

  // ****************************************************************
  // Device registers
  // ****************************************************************
  localparam logic [7:0] WIPER_RST = 8'h40;
  localparam logic [7:0] ACCESS_RST = 8'h40;
  localparam logic [7:0] ACCESS_MASK = 8'h42;
  localparam int ACC_ENABLE_BIT = 6;
  localparam int ACC_ODRAIN_BIT = 1;

  // ****************************************************************
  // Host registers (APB byte offsets)
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_TX = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CMD_OPEN = 0;
  localparam int CMD_SHIFT = 1;
  localparam int CMD_CLOSE = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SELECTED = 1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int CS_HIGH_NS = 80;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int HALF_DEF = 4;

  typedef enum logic [5:0] {
    HS_IDLE = 6'h01,
    HS_SETUP = 6'h02,
    HS_HI = 6'h04,
    HS_LO = 6'h08,
    HS_GAP = 6'h10,
    HS_HOLD = 6'h20
  } sdp_hstate_t;

endpackage

// ==== sdp_spi_if.sv ====
`timescale 1ns/100ps
interface sdp_spi_if;
  logic sck;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // Pull-up on the output line: undriven or open-drain high reads 1
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport host (
    output sck,
    output cs_n,
    output sdi,
    input sdo_line
  );

  modport dev (
    input sck,
    input cs_n,
    input sdi,
    output sdo,
    output sdo_oe
  );
endinterface

// ==== sdp_dev.sv ====
`timescale 1ns/100ps
// What this block does
// RULE1: Address 00000b is wiper, 10000b access control
// RULE2: Wiper register drives tap, reads back value
// RULE3: Host chains devices, shares select and clock
// RULE4: Chained write: N two-byte commands per frame
// RULE5: Host sends last device's command first
// RULE6: All devices execute write at select rise
// RULE7: Chained read: N read commands, reverse order
// RULE8: Read command plus dummy byte, then deselect
// RULE9: Latched read executes in second frame
// RULE10: Second frame: N no-op words, then deselect
// RULE11: Even output bytes carry register data
// RULE12: Odd output bytes carry 111b and address
// RULE13: Device is a sixteen-bit shift stage
// RULE14: Mode 0, MSB first, sample rise, shift fall
// RULE15: Opcode upper three bits, address lower five
// RULE16: Output released while chip select high
// RULE17: Wiper powers up at mid-scale 40h
module sdp_dev (
  input wire logic pclk,
  input wire logic presetn,
  sdp_spi_if.dev link,
  output logic [7:0] wiper,
  output logic pot_enable,
  output logic sdo_open_drain
);
  import sdp_pkg::*;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    logic [WORD_W-1:0] sh;
  } sdp_shift_t;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic [7:0] wiper;
    logic [7:0] access;
    logic [WORD_W-1:0] resp;
    logic rd_pend;
  } sdp_core_t;

  sdp_shift_t s;
  sdp_shift_t next_s;
  sdp_core_t r;
  sdp_core_t next_r;
  logic [4:0] cnt;
  logic sdo_q;
  logic next_sdo;

  // ****************************************************************
  // Link domain: input shift register
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.sh = {s.sh[WORD_W-2:0], link.sdi}; // RULE13 RULE14
  end

  // Not reset by chip select: the held word must survive the rise
  always_ff @(posedge link.sck or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Cleared asynchronously: sck is idle while the select is high
  // Edges seen in this frame, saturating at one word
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt <= 5'h00;
    end else if (cnt != WORD_BITS) begin
      cnt <= cnt + 5'h01;
    end
  end

  // ****************************************************************
  // Link domain: output stage
  // ****************************************************************
  // Reply bits until one word has gone, then the plain shift stage.
  // Response bit 15 leaves through the preset, so the index starts at 14.
  always_comb begin
    next_sdo = s.sh[WORD_W-1]; // RULE13
    if (r.rd_pend && cnt != WORD_BITS) begin
      next_sdo = r.resp[4'hf - cnt[3:0]]; // RULE9 RULE11 RULE12 RULE14
    end
  end

  // Preset to 1 while deselected: this is the first bit of every frame,
  // which matches the leading 1 of a read response word.
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      sdo_q <= 1'b1;
    end else begin
      sdo_q <= next_sdo;
    end
  end

  // resp, rd_pend and access only change while chip select is high,
  // so the link side sees them frozen for a whole frame.
  assign link.sdo = sdo_q;
  // Open drain: only zeros are driven, the pull-up gives the ones
  assign link.sdo_oe = !link.cs_n && (!r.access[ACC_ODRAIN_BIT] || !sdo_q); // RULE16

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  function automatic logic [7:0] read_value(
    input logic [4:0] addr,
    input logic [7:0] wiper_v,
    input logic [7:0] access_v
  );
    logic [7:0] v;
    v = 8'h00;
    if (addr == ADDR_WIPER) begin
      v = wiper_v; // RULE1 RULE2
    end else if (addr == ADDR_ACCESS) begin
      v = access_v; // RULE1
    end
    return v;
  endfunction

  // ****************************************************************
  // Core domain: select synchroniser and command execution
  // ****************************************************************
  logic cs_rise;
  logic [2:0] op;
  logic [4:0] addr;
  logic [7:0] data;

  // Two stages settle the pin, the third finds its rising edge
  assign cs_rise = r.cs2 && !r.cs3;
  // Shift word is static once chip select is high and the clock idles
  assign op = s.sh[OP_MSB:OP_LSB]; // RULE15
  assign addr = s.sh[ADR_MSB:ADR_LSB]; // RULE15
  assign data = s.sh[DAT_MSB:0];

  // ****************************************************************
  // Core domain: read response word
  // ****************************************************************
  // Echo byte first, so the host can tell which register answered
  logic [4:0] rd_addr;
  logic [WORD_W-1:0] rd_word;

  // The old access read carries no usable address field
  assign rd_addr = (op == OP_ACC_RD) ? ADDR_ACCESS : addr; // RULE1
  assign rd_word = {ECHO_CODE, rd_addr, read_value(rd_addr, r.wiper, r.access)}; // RULE12

  always_comb begin
    next_r = r;
    next_r.cs1 = link.cs_n;
    next_r.cs2 = r.cs1;
    next_r.cs3 = r.cs2;
    if (cs_rise) begin // RULE6
      // Any frame that ends without a read clears the pending response
      next_r.rd_pend = 1'b0;
      case (op)
        OP_WRITE: begin
          if (addr == ADDR_WIPER) begin // RULE1
            next_r.wiper = data; // RULE2 RULE6
          end else if (addr == ADDR_ACCESS) begin // RULE1
            next_r.access = data & ACCESS_MASK; // RULE6
          end
        end
        OP_ACC_WT: begin
          next_r.access = data & ACCESS_MASK;
        end
        OP_READ: begin
          next_r.rd_pend = 1'b1; // RULE9
          next_r.resp = rd_word; // RULE12 RULE11
        end
        OP_ACC_RD: begin
          next_r.rd_pend = 1'b1;
          next_r.resp = rd_word; // RULE11
        end
        default: begin
          next_r.rd_pend = 1'b0;
        end
      endcase
    end
  end

  // Wiper and access survive frames; only presetn restores them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.cs1 <= 1'b1;
      r.cs2 <= 1'b1;
      r.cs3 <= 1'b1;
      r.wiper <= WIPER_RST; // RULE17
      r.access <= ACCESS_RST;
      r.resp <= '0;
      r.rd_pend <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // User outputs
  // ****************************************************************
  // Shutdown bit and output mode come straight from the register
  assign wiper = r.wiper; // RULE2
  assign pot_enable = r.access[ACC_ENABLE_BIT];
  assign sdo_open_drain = r.access[ACC_ODRAIN_BIT];

endmodule

// ==== sdp_host.sv ====
`timescale 1ns/100ps
module sdp_host #(
  parameter int HALF = sdp_pkg::HALF_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sdp_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sdp_spi_if.host link
);
  import sdp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sdp_hstate_t st;
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] sh;
    logic [WORD_W-1:0] rx;
    logic [4:0] bits;
    logic [7:0] cnt;
    logic do_shift;
    logic do_close;
    logic sck;
    logic cs_n;
    logic sdi;
    logic m1;
    logic m2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sdp_host_t;

  sdp_host_t r;
  sdp_host_t next_r;
  logic access;
  logic wr_fire;
  logic busy;

  localparam logic [7:0] HALF_LD = 8'(HALF - 1);
  localparam logic [7:0] HOLD_LD = 8'(CS_HIGH_CYC - 1);

  assign access = psel && penable;
  assign wr_fire = access && r.pready && pwrite;
  assign busy = r.st != HS_IDLE;

  always_comb begin
    next_r = r;
    next_r.m1 = link.sdo_line;
    next_r.m2 = r.m1;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;

    // ****************************************************************
    // APB slave: one wait state, writes land at the pready edge
    // ****************************************************************
    if (access && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0000_0000;
      if (paddr == REG_TX) begin
        next_r.prdata = {16'h0000, r.tx};
      end else if (paddr == REG_CMD) begin
        next_r.prdata = 32'h0000_0000;
      end else if (paddr == REG_RX) begin
        next_r.prdata = {16'h0000, r.rx};
      end else if (paddr == REG_STAT) begin
        next_r.prdata = {30'h0000_0000, !r.cs_n, busy};
      end else begin
        next_r.pslverr = 1'b1;
      end
    end

    // Word goes out as written: software queues far-end commands first
    if (wr_fire && paddr == REG_TX) begin
      next_r.tx = pwdata[WORD_W-1:0]; // RULE5 RULE15
    end

    // ****************************************************************
    // Frame sequencer
    // ****************************************************************
    case (r.st)
      HS_IDLE: begin
        // Commands written while busy are dropped
        if (wr_fire && paddr == REG_CMD) begin
          next_r.do_shift = pwdata[CMD_SHIFT];
          next_r.do_close = pwdata[CMD_CLOSE];
          if (pwdata[CMD_OPEN]) begin
            next_r.cs_n = 1'b0; // RULE3 RULE4 RULE7
          end
          next_r.sh = r.tx;
          next_r.sdi = r.tx[WORD_W-1]; // RULE14
          next_r.cnt = HALF_LD;
          next_r.st = HS_SETUP;
        end
      end
      HS_SETUP: begin
        if (r.cnt == 8'h00) begin
          next_r.cnt = HALF_LD;
          if (r.do_shift) begin
            next_r.sck = 1'b1;
            next_r.bits = WORD_BITS;
            next_r.st = HS_HI;
          end else begin
            next_r.st = HS_GAP;
          end
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      HS_HI: begin
        if (r.cnt == 8'h00) begin
          // Line settled since the last fall; two-stage sync is enough
          next_r.rx = {r.rx[WORD_W-2:0], r.m2}; // RULE14
          next_r.sck = 1'b0;
          next_r.sh = {r.sh[WORD_W-2:0], 1'b0}; // RULE4 RULE7 RULE10
          next_r.sdi = r.sh[WORD_W-2];
          next_r.bits = r.bits - 5'h01;
          next_r.cnt = HALF_LD;
          next_r.st = (r.bits == 5'h01) ? HS_GAP : HS_LO;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      HS_LO: begin
        if (r.cnt == 8'h00) begin
          next_r.sck = 1'b1; // RULE14
          next_r.cnt = HALF_LD;
          next_r.st = HS_HI;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      HS_GAP: begin
        if (r.cnt == 8'h00) begin
          if (r.do_close) begin
            next_r.cs_n = 1'b1; // RULE8 RULE10
            next_r.cnt = HOLD_LD;
            next_r.st = HS_HOLD;
          end else begin
            next_r.st = HS_IDLE;
          end
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      HS_HOLD: begin
        // Devices need this long to execute before the next frame
        if (r.cnt == 8'h00) begin
          next_r.st = HS_IDLE;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      default: begin
        next_r.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= HS_IDLE;
      r.cs_n <= 1'b1;
      r.m1 <= 1'b1;
      r.m2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.sck = r.sck; // RULE3
  assign link.cs_n = r.cs_n; // RULE3
  assign link.sdi = r.sdi;
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;

endmodule

// ==== sdp_link_checker.sv ====
`timescale 1ns/100ps
module sdp_link_checker #(
  parameter int HALF = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int hi_cnt;
  int rise_cnt;
  // ****************************
  // Helper counters
  // ****************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 0;
      rise_cnt <= 0;
    end else begin
      hi_cnt <= sck ? hi_cnt + 1 : 0;
      if (cs_n) begin
        rise_cnt <= 0;
      end else if ($rose(sck)) begin
        rise_cnt <= rise_cnt + 1;
      end
    end
  end
  property p_oe_off;
    cs_n |-> !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck active outside frame");
  property p_sdi_hold;
    $rose(sck) |-> $stable(sdi);
  endproperty
  a_sdi_hold: assert property (p_sdi_hold) else $error("sdi moved at sck rise");
  property p_sdo_hold;
    sck && $past(sck) |-> $stable(sdo);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved while sck high");
  property p_half;
    $fell(sck) |-> hi_cnt == HALF;
  endproperty
  a_half: assert property (p_half) else $error("sck high phase wrong length");
  property p_cs_gap;
    $rose(cs_n) |=> cs_n [*7];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select high gap too short");
  property p_words;
    $rose(cs_n) |-> rise_cnt != 0 && rise_cnt % 16 == 0;
  endproperty
  a_words: assert property (p_words) else $error("frame not whole words");
  property p_first_rise;
    $fell(cs_n) |-> !sck [*4] ##1 sck;
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first sck rise late");
  c_two_words: cover property ($rose(cs_n) && rise_cnt == 32);
  c_three_words: cover property ($rose(cs_n) && rise_cnt == 48);
  c_released: cover property (!cs_n && !sdo_oe);
endmodule

// ==== tb_spi_daisy_chain_pot_access.sv ====
`timescale 1ns/100ps
module tb_spi_daisy_chain_pot_access;
  import sdp_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] wiper [2];
  logic pot_en [2];
  logic odrain [2];
  logic [31:0] rdata;
  logic rerr;
  logic [15:0] wl [4];
  logic [15:0] rl [4];
  int bad_count;
  int n_tests;
  // ****************************
  // Chain of two devices
  // ****************************
  sdp_spi_if if_h();
  sdp_spi_if if_d0();
  sdp_spi_if if_d1();
  assign if_d0.sck = if_h.sck;
  assign if_d0.cs_n = if_h.cs_n;
  assign if_d0.sdi = if_h.sdi;
  assign if_d1.sck = if_h.sck;
  assign if_d1.cs_n = if_h.cs_n;
  assign if_d1.sdi = if_d0.sdo_line;
  assign if_h.sdo = if_d1.sdo;
  assign if_h.sdo_oe = if_d1.sdo_oe;
  sdp_host #(.HALF(4)) i_sdp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(if_h.host));
  sdp_dev i_sdp_dev0 (.pclk(pclk), .presetn(presetn), .link(if_d0.dev), .wiper(wiper[0]),
    .pot_enable(pot_en[0]), .sdo_open_drain(odrain[0]));
  sdp_dev i_sdp_dev1 (.pclk(pclk), .presetn(presetn), .link(if_d1.dev), .wiper(wiper[1]),
    .pot_enable(pot_en[1]), .sdo_open_drain(odrain[1]));
  sdp_link_checker #(.HALF(4)) i_sdp_link_checker (.pclk(pclk), .presetn(presetn),
    .sck(if_d0.sck), .cs_n(if_d0.cs_n), .sdi(if_d0.sdi), .sdo(if_d0.sdo),
    .sdo_oe(if_d0.sdo_oe));
  // ****************************
  // Bus and check tasks
  // ****************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("[ERR] apb pready expected 1 seen %b", pready);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input int n, input logic cl);
    int k;
    for (int i = 0; i < n; i++) begin
      apb(1'b1, REG_TX, {16'h0, wl[i]});
      apb(1'b1, REG_CMD, {29'h0, cl && i == n - 1, 1'b1, i == 0});
      k = 0;
      do begin
        apb(1'b0, REG_STAT, 32'h0);
        k++;
      end while (rdata[STAT_BUSY] !== 1'b0 && k < 400);
      if (rdata[STAT_BUSY] !== 1'b0) begin
        bad_count++;
        $display("[ERR] busy expected 0 seen %b", rdata[STAT_BUSY]);
      end
      apb(1'b0, REG_RX, 32'h0);
      rl[i] = rdata[15:0];
    end
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset;
    for (int i = 0; i < 2; i++) begin
      chk("wiper", 16'h0040, {8'h0, wiper[i]});
      chk("pot_enable", 16'h0001, {15'h0, pot_en[i]});
      chk("open_drain", 16'h0000, {15'h0, odrain[i]});
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 16'h0001, {15'h0, rerr});
    $display("reset test done");
  endtask
  task automatic t_shift;
    // Nop words with stray bits pass two stages unchanged
    wl = '{16'h0abc, 16'h1234, 16'h0000, 16'h0};
    send(3, 1'b1);
    chk("two stage delay", 16'h0abc, rl[2]);
    chk("nop wiper", 16'h0040, {8'h0, wiper[1]});
    $display("shift test done");
  endtask
  task automatic t_write;
    wl = '{16'hc015, 16'hc02a, 16'h0, 16'h0};
    send(2, 1'b0);
    chk("wiper before rise", 16'h0040, {8'h0, wiper[0]});
    apb(1'b1, REG_CMD, 32'h4);
    repeat (40) @(posedge pclk);
    chk("far wiper", 16'h0015, {8'h0, wiper[1]});
    chk("near wiper", 16'h002a, {8'h0, wiper[0]});
    $display("write test done");
  endtask
  task automatic t_read(input logic [15:0] c1, input logic [15:0] c0,
                        input logic [15:0] e1, input logic [15:0] e0);
    wl = '{c1, c0, 16'h0, 16'h0};
    send(2, 1'b1);
    wl = '{16'h0, 16'h0, 16'h0, 16'h0};
    send(2, 1'b1);
    chk("far reply", e1, rl[0]);
    chk("near reply", e0, rl[1]);
    $display("read test done");
  endtask
  task automatic t_access;
    // Old access opcode on the far device, masked full write on the near one
    wl = '{16'h6002, 16'hd0ff, 16'h0, 16'h0};
    send(2, 1'b1);
    repeat (40) @(posedge pclk);
    chk("far enable", 16'h0000, {15'h0, pot_en[1]});
    chk("far drain", 16'h0001, {15'h0, odrain[1]});
    chk("near enable", 16'h0001, {15'h0, pot_en[0]});
    chk("near drain", 16'h0001, {15'h0, odrain[0]});
    t_read(16'h9000, 16'h9000, 16'hf002, 16'hf042);
    // Old access read opcode on the far device, wiper read on the near one
    t_read(16'h2000, 16'h8000, 16'hf002, 16'he02a);
    $display("access test done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #500000;
    bad_count++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    t_reset();
    t_shift();
    t_write();
    t_read(16'h8000, 16'h9000, 16'he015, 16'hf040);
    t_access();
    finish_test();
  end
endmodule
